// ### core/dfcd_top.sv
// Digital frequency command decoder: capture, decode, scale and source selection
//
// Notes on behaviour
// - Increment selection takes values 0 to 3 and is 1 after reset.
// - Increment selection only matters when the active gain holds the direct-value code.
// - Set frequency is the decoded value times 10, 1, 0.1 or 0.01 Hz for selection 0 to 3.
// - With any other gain value the increment selection is ignored.
// - In BCD mode a digit of A to F is discarded and the last valid value is kept.
// - Switching from binary to BCD while a digit of A to F is present sets zero.
// - With digital input on, multi-speed, current select and analog inputs are ignored.
// - Restart select stays effective while the restart coast time is not disabled.
// - Analog compensation is added only for methods 2, 3, 12 and 13.
// - Source priority is inching, multi-speed, PID, current select, then voltage.
// - Ramps are timed against the reference frequency exactly as for analog commands.
// - Methods 0 to 3 use 12 bits or 3 digits, methods 10 to 13 use all 16 bits.
// - Increment writes are refused while running and parameter clear leaves it alone.
// - With read timing 1 the inputs are captured only while the read strobe is high.
// - With the direct-value code the decoded value is the frequency, with no bias.
`timescale 1ns/10ps
`default_nettype none
module dfcd_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] digital_command_bits_i,
  input wire logic read_strobe_i,
  input wire logic inching_operation_i,
  input wire logic [3:0] multi_speed_inputs_i,
  input wire logic pid_select_i,
  input wire logic current_input_select_i,
  input wire logic restart_select_i,
  input wire logic running_i,
  input wire logic [13:0] input_method_select_i,
  input wire logic [3:0] read_timing_select_i,
  input wire logic [15:0] bcd_gain_setting_i,
  input wire logic [15:0] binary_gain_setting_i,
  input wire logic [13:0] restart_coast_time_i,
  input wire logic [15:0] ramp_reference_frequency_i,
  input wire logic increment_wr_i,
  input wire logic [1:0] increment_wdata_i,
  input wire logic [15:0] analog_comp_i,
  input wire logic [15:0] inching_freq_i,
  input wire logic [15:0] multi_speed_freq_i,
  input wire logic [15:0] pid_freq_i,
  input wire logic [15:0] current_freq_i,
  input wire logic [15:0] voltage_freq_i,
  output logic [26:0] set_freq_o,
  output dfcd_pkg::dfcd_src_e source_o,
  output logic [1:0] increment_select_o,
  output logic increment_refused_o,
  output logic direct_mode_o,
  output logic bcd_reject_o,
  output logic restart_select_o,
  output logic [15:0] ramp_reference_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a bit moves only once stages two and three agree

  logic [dfcd_pkg::PIN_W-1:0] pin_raw;
  logic [dfcd_pkg::PIN_W-1:0] pin_s1;
  logic [dfcd_pkg::PIN_W-1:0] pin_s2;
  logic [dfcd_pkg::PIN_W-1:0] pin_s3;
  logic [dfcd_pkg::PIN_W-1:0] pin_f;

  assign pin_raw = {restart_select_i, current_input_select_i, pid_select_i,
                    multi_speed_inputs_i, inching_operation_i, read_strobe_i,
                    digital_command_bits_i};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  logic strobe_f;
  logic inch_f;
  logic multi_f;
  logic pid_f;
  logic cur_f;
  logic restart_f;

  assign strobe_f = pin_f[dfcd_pkg::PIN_STROBE];
  assign inch_f = pin_f[dfcd_pkg::PIN_INCH];
  assign multi_f = |pin_f[dfcd_pkg::PIN_MS_LSB +: 4];
  assign pid_f = pin_f[dfcd_pkg::PIN_PID];
  assign cur_f = pin_f[dfcd_pkg::PIN_CUR];
  assign restart_f = pin_f[dfcd_pkg::PIN_RESTART];

  ////////////////////////////////////////////////////////////////////////////
  // Command capture; reset leaves all command bits off until read

  logic [15:0] cmd_cap;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_cap <= '0;
    end else if (read_timing_select_i == dfcd_pkg::TIMING_STROBE) begin
      if (strobe_f) begin
        cmd_cap <= pin_f[dfcd_pkg::PIN_CMD_LSB +: 16];
      end
    end else begin
      cmd_cap <= pin_f[dfcd_pkg::PIN_CMD_LSB +: 16];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input method decode; unknown codes behave as no function

  logic dig_active;
  logic bcd;
  logic wide;
  logic comp_en;

  always_comb begin
    dig_active = 1'b1;
    bcd = 1'b0;
    wide = 1'b0;
    comp_en = 1'b0;
    // compensation only for the four compensated methods
    case (input_method_select_i)
      dfcd_pkg::M_BCD3: bcd = 1'b1;
      dfcd_pkg::M_BIN12: bcd = 1'b0;
      dfcd_pkg::M_BCD3_COMP: begin
        bcd = 1'b1;
        comp_en = 1'b1;
      end
      dfcd_pkg::M_BIN12_COMP: comp_en = 1'b1;
      dfcd_pkg::M_BCD4: begin
        bcd = 1'b1;
        wide = 1'b1;
      end
      dfcd_pkg::M_BIN16: wide = 1'b1;
      dfcd_pkg::M_BCD4_COMP: begin
        bcd = 1'b1;
        wide = 1'b1;
        comp_en = 1'b1;
      end
      dfcd_pkg::M_BIN16_COMP: begin
        wide = 1'b1;
        comp_en = 1'b1;
      end
      default: dig_active = 1'b0;
    endcase
  end

  dfcd_dec_if dif ();

  assign dif.raw = cmd_cap;
  assign dif.wide = wide;
  assign dif.bcd = bcd;

  dfcd_decode u_decode (
    .dif(dif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Held digital value

  logic prev_bcd;
  logic [15:0] dig_value;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_bcd <= 1'b0;
      bcd_reject_o <= 1'b0;
    end else begin
      prev_bcd <= bcd & dig_active;
      bcd_reject_o <= dif.bad_digit & dig_active;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dig_value <= '0;
    end else if (!dig_active) begin
      dig_value <= '0;
    end else if (dif.bad_digit) begin
      // fresh switch into BCD with a bad digit gives zero
      if (!prev_bcd) begin
        dig_value <= '0;
      end
      // otherwise the last valid value is kept
    end else begin
      dig_value <= dif.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Increment selection; no clear input reaches it by design

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      increment_select_o <= dfcd_pkg::INC_RESET;
      increment_refused_o <= 1'b0;
    end else begin
      increment_refused_o <= increment_wr_i & running_i;
      if (increment_wr_i && !running_i) begin
        increment_select_o <= increment_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling into 0.01 Hz counts

  logic direct;
  logic [9:0] factor;
  logic [26:0] scaled_q;
  logic [26:0] comp_q;

  // direct code of the active coding's gain
  assign direct = bcd ? (bcd_gain_setting_i == dfcd_pkg::GAIN_DIRECT)
                      : (binary_gain_setting_i == dfcd_pkg::GAIN_DIRECT);

  always_comb begin
    // raw count passes unscaled for the gain line downstream
    factor = dfcd_pkg::SCALE_RAW;
    if (direct) begin
      case (increment_select_o)
        dfcd_pkg::INC_10HZ: factor = dfcd_pkg::SCALE_10HZ;
        dfcd_pkg::INC_1HZ: factor = dfcd_pkg::SCALE_1HZ;
        dfcd_pkg::INC_0P1HZ: factor = dfcd_pkg::SCALE_0P1HZ;
        dfcd_pkg::INC_0P01HZ: factor = dfcd_pkg::SCALE_0P01HZ;
        default: factor = dfcd_pkg::SCALE_RAW;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scaled_q <= '0;
      comp_q <= '0;
      direct_mode_o <= 1'b0;
    end else begin
      // 27 bits hold 65535 x 1000 plus compensation
      scaled_q <= 27'(dig_value) * 27'(factor);
      comp_q <= comp_en ? 27'(analog_comp_i) : '0;
      direct_mode_o <= direct & dig_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source priority and outputs

  dfcd_pkg::dfcd_src_e next_src;
  logic [26:0] next_freq;

  always_comb begin
    // digital mode masks multi-speed, current and analog sources
    if (inch_f) begin
      next_src = dfcd_pkg::DFCD_SRC_INCH;
      next_freq = 27'(inching_freq_i);
    end else if (!dig_active && multi_f) begin
      next_src = dfcd_pkg::DFCD_SRC_MULTI;
      next_freq = 27'(multi_speed_freq_i);
    end else if (pid_f) begin
      next_src = dfcd_pkg::DFCD_SRC_PID;
      next_freq = 27'(pid_freq_i);
    end else if (dig_active) begin
      next_src = dfcd_pkg::DFCD_SRC_DIG;
      next_freq = scaled_q + comp_q;
    end else if (cur_f) begin
      next_src = dfcd_pkg::DFCD_SRC_CUR;
      next_freq = 27'(current_freq_i);
    end else begin
      next_src = dfcd_pkg::DFCD_SRC_VOLT;
      next_freq = 27'(voltage_freq_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      set_freq_o <= '0;
      source_o <= dfcd_pkg::DFCD_SRC_VOLT;
      restart_select_o <= 1'b0;
      ramp_reference_o <= '0;
    end else begin
      set_freq_o <= next_freq;
      source_o <= next_src;
      // restart select survives digital mode unless disabled
      restart_select_o <= restart_f &
                          (!dig_active || restart_coast_time_i != dfcd_pkg::COAST_DISABLE);
      // same ramp reference as analog commands
      ramp_reference_o <= ramp_reference_frequency_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_strobe_low;
    read_timing_select_i == dfcd_pkg::TIMING_STROBE && !strobe_f;
  endsequence

  sequence s_bad_in_bcd;
    dig_active && dif.bad_digit && prev_bcd;
  endsequence

  sequence s_fresh_switch;
    dig_active && dif.bad_digit && !prev_bcd;
  endsequence

  a_inc_run_lock: assert property (
    increment_wr_i && running_i |=> $stable(increment_select_o))
    else $error("increment changed while running");

  a_inc_stop_write: assert property (
    increment_wr_i && !running_i |=> increment_select_o == $past(increment_wdata_i))
    else $error("increment write while stopped not taken");

  a_strobe_hold_cap: assert property (
    s_strobe_low |=> $stable(cmd_cap))
    else $error("command captured with strobe low");

  a_bcd_bad_hold: assert property (
    s_bad_in_bcd |=> $stable(dig_value))
    else $error("bad BCD digit not discarded");

  a_switch_zero: assert property (
    s_fresh_switch |=> dig_value == 16'h0000)
    else $error("switch to BCD with bad digit not zero");

  a_narrow_mask: assert property (
    !wide |-> dif.value < 16'h1000)
    else $error("narrow mode value uses upper bits");

  a_scale_ten: assert property (
    direct && increment_select_o == dfcd_pkg::INC_10HZ
      |=> scaled_q == 27'($past(dig_value)) * 27'(dfcd_pkg::SCALE_10HZ))
    else $error("10 Hz increment scaling wrong");

  a_scale_ignored: assert property (
    !direct |=> scaled_q == 27'($past(dig_value)))
    else $error("increment applied without direct gain");

  a_comp_gate: assert property (
    !comp_en |=> comp_q == 27'h0000000)
    else $error("compensation added in wrong method");

  a_restart_gate: assert property (
    dig_active && restart_coast_time_i == dfcd_pkg::COAST_DISABLE |=> !restart_select_o)
    else $error("restart select passed while disabled");

  a_inch_first: assert property (
    inch_f |=> source_o == dfcd_pkg::DFCD_SRC_INCH ##1 1'b1)
    else $error("inching did not win");

  a_dig_masks: assert property (
    dig_active && !inch_f && !pid_f |=> source_o == dfcd_pkg::DFCD_SRC_DIG)
    else $error("digital mode lost to masked source");

endmodule : dfcd_top
`default_nettype wire

// ### shared/dfcd_pkg.sv
// Constants and types shared by the digital frequency command decoder
package dfcd_pkg;
  // Codes that mean "no function" or "use the input value directly"
  localparam logic [13:0] METHOD_NONE = 14'h270F;
  localparam logic [15:0] GAIN_DIRECT = 16'h270F;
  localparam logic [13:0] COAST_DISABLE = 14'h270F;
  // Input method codes
  localparam logic [13:0] M_BCD3 = 14'h0000;
  localparam logic [13:0] M_BIN12 = 14'h0001;
  localparam logic [13:0] M_BCD3_COMP = 14'h0002;
  localparam logic [13:0] M_BIN12_COMP = 14'h0003;
  localparam logic [13:0] M_BCD4 = 14'h000A;
  localparam logic [13:0] M_BIN16 = 14'h000B;
  localparam logic [13:0] M_BCD4_COMP = 14'h000C;
  localparam logic [13:0] M_BIN16_COMP = 14'h000D;
  // Read timing codes; the filtered code behaves as always-read here
  localparam logic [3:0] TIMING_ALWAYS = 4'h0;
  localparam logic [3:0] TIMING_STROBE = 4'h1;
  localparam logic [3:0] TIMING_FILTER = 4'hA;
  // Increment selection codes and reset value
  localparam logic [1:0] INC_10HZ = 2'h0;
  localparam logic [1:0] INC_1HZ = 2'h1;
  localparam logic [1:0] INC_0P1HZ = 2'h2;
  localparam logic [1:0] INC_0P01HZ = 2'h3;
  localparam logic [1:0] INC_RESET = INC_1HZ;
  // Multipliers into 0.01 Hz counts
  localparam logic [9:0] SCALE_10HZ = 10'h3E8;
  localparam logic [9:0] SCALE_1HZ = 10'h064;
  localparam logic [9:0] SCALE_0P1HZ = 10'h00A;
  localparam logic [9:0] SCALE_0P01HZ = 10'h001;
  localparam logic [9:0] SCALE_RAW = 10'h001;
  // Widths
  localparam int CMD_W = 16;
  localparam int FREQ_W = 27;
  localparam int SRC_FREQ_W = 16;
  localparam int PIN_W = 25;
  // Field positions in the synchronised pin vector
  localparam int PIN_CMD_LSB = 0;
  localparam int PIN_STROBE = 16;
  localparam int PIN_INCH = 17;
  localparam int PIN_MS_LSB = 18;
  localparam int PIN_PID = 22;
  localparam int PIN_CUR = 23;
  localparam int PIN_RESTART = 24;
  // Winning frequency source
  typedef enum logic [2:0] {
    DFCD_SRC_VOLT = 3'h0,
    DFCD_SRC_CUR = 3'h1,
    DFCD_SRC_MULTI = 3'h2,
    DFCD_SRC_PID = 3'h3,
    DFCD_SRC_INCH = 3'h6,
    DFCD_SRC_DIG = 3'h7
  } dfcd_src_e;
endpackage : dfcd_pkg

// ### shared/dfcd_dec_if.sv
// Carrier between the top module and the command digit decoder
`timescale 1ns/10ps
`default_nettype none
interface dfcd_dec_if;
  logic [15:0] raw;
  logic wide;
  logic bcd;
  logic [15:0] value;
  logic bad_digit;
  modport host (output raw, output wide, output bcd, input value, input bad_digit);
  modport dec (input raw, input wide, input bcd, output value, output bad_digit);
endinterface : dfcd_dec_if
`default_nettype wire

// ### core/dfcd_decode.sv
// Combinational BCD or binary decode of the captured command word
`timescale 1ns/10ps
`default_nettype none
module dfcd_decode (
  dfcd_dec_if.dec dif
);
  logic [15:0] masked;
  logic [3:0] nib_bad;

  assign masked = dif.wide ? dif.raw : {4'h0, dif.raw[11:0]};

  for (genvar g = 0; g < 4; g++) begin : g_nib
    assign nib_bad[g] = masked[4*g+3 -: 4] > 4'h9;
  end

  always_comb begin
    dif.bad_digit = dif.bcd && (|nib_bad);
    if (dif.bcd) begin
      dif.value = 16'(masked[15:12] * 16'h03E8) + 16'(masked[11:8] * 16'h0064)
                + 16'(masked[7:4] * 16'h000A) + 16'(masked[3:0]);
    end else begin
      dif.value = masked;
    end
  end
endmodule : dfcd_decode
`default_nettype wire

// ### bench/dfcd_ctrl_model.sv
// Model of the controller that drives the parallel command pins
`timescale 1ns/10ps
`default_nettype none
module dfcd_ctrl_model (
  input wire logic clk_i,
  output logic [15:0] bits_o,
  output logic strobe_o
);
  initial begin
    bits_o = 16'h0000;
    strobe_o = 1'b0;
  end
  // Strobed words are scrambled once released, so a stale capture shows up
  task automatic put(input logic [15:0] w, input bit strobed, input int hold);
    @(negedge clk_i);
    bits_o = w;
    strobe_o = strobed;
    repeat (hold) @(negedge clk_i);
    if (strobed) begin
      strobe_o = 1'b0;
      @(negedge clk_i);
      bits_o = ~w;
    end
  endtask : put
  task automatic manual_zero();
    put(16'h0000, 1'b0, 6);
  endtask : manual_zero
endmodule : dfcd_ctrl_model
`default_nettype wire

// ### bench/dfcd_tb_top.sv
// Self-checking bench for the digital frequency command decoder
`timescale 1ns/10ps
`default_nettype none
module dfcd_tb_top;
  logic clk_i, nrst_i, strb, inch, pid, cur, rs_in, run, wr, refused, direct, rej, rsel;
  logic [15:0] cmd, gbcd, gbin, ramp, comp, f_in, f_ms, f_pid, f_cur, f_v, ramp_o;
  logic [13:0] method, coast;
  logic [3:0] ms, timing;
  logic [1:0] wdata, inc;
  logic [26:0] freq;
  logic [79:0] fv;
  dfcd_pkg::dfcd_src_e src;
  int fails, samples_checked, cycles, m, sel, last, n;
  logic [31:0] rng;
  dfcd_ctrl_model dfcd_ctrl_model_inst (.clk_i(clk_i), .bits_o(cmd), .strobe_o(strb));
  dfcd_top dfcd_top_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .digital_command_bits_i(cmd), .read_strobe_i(strb),
    .inching_operation_i(inch), .multi_speed_inputs_i(ms), .pid_select_i(pid),
    .current_input_select_i(cur), .restart_select_i(rs_in), .running_i(run),
    .input_method_select_i(method), .read_timing_select_i(timing),
    .bcd_gain_setting_i(gbcd), .binary_gain_setting_i(gbin), .restart_coast_time_i(coast),
    .ramp_reference_frequency_i(ramp), .increment_wr_i(wr), .increment_wdata_i(wdata),
    .analog_comp_i(comp), .inching_freq_i(f_in), .multi_speed_freq_i(f_ms),
    .pid_freq_i(f_pid), .current_freq_i(f_cur), .voltage_freq_i(f_v), .set_freq_o(freq),
    .source_o(src), .increment_select_o(inc), .increment_refused_o(refused),
    .direct_mode_o(direct), .bcd_reject_o(rej), .restart_select_o(rsel),
    .ramp_reference_o(ramp_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // Returns -1 in BCD methods for a word holding a decoded digit above nine; binary methods return the word
  function automatic int decode(input int w);
    int v;
    v = 0;
    if (m < 4) w = w & 'hFFF;
    if (m % 2) return w;
    for (int i = 3; i >= 0; i--) begin
      if (((w >> 4 * i) & 15) > 9) return -1;
      v = v * 10 + ((w >> 4 * i) & 15);
    end
    return v;
  endfunction : decode
  function automatic int exp_f();
    int s[4] = '{1000, 100, 10, 1};
    logic [15:0] g;
    g = (m % 2) ? gbin : gbcd;
    return last * ((g == dfcd_pkg::GAIN_DIRECT) ? s[sel] : 1) + ((m % 10 >= 2) ? int'(comp) : 0);
  endfunction : exp_f
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (12) @(negedge clk_i);
  endtask : settle
  task automatic set_m(input int v);
    m = v;
    method = 14'(v);
  endtask : set_m
  task automatic send(input logic [15:0] w);
    int d;
    dfcd_ctrl_model_inst.put(w, timing == 4'h1, 6);
    settle();
    d = decode(int'(w));
    if (d >= 0) last = d;
  endtask : send
  task automatic wr_inc(input int s);
    @(negedge clk_i);
    wr = 1'b1;
    wdata = 2'(s);
    @(negedge clk_i);
    wr = 1'b0;
    n = 0;
    repeat (3) begin
      n += int'(refused === 1'b1);
      @(negedge clk_i);
    end
    if (!run) sel = s;
  endtask : wr_inc
  task automatic end_test(input string name);
    $display("test %s done: %0d checks, %0d failures", name, samples_checked, fails);
  endtask : end_test
  task automatic stop_test();
    $display("checks made %0d, failures %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // Ceiling is several times the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst_i = 1'b0;
    {inch, pid, cur, rs_in, run, wr} = '0;
    {ms, timing, wdata, comp} = '0;
    {f_in, f_ms, f_pid, f_cur, f_v} = {16'h0101, 16'h0202, 16'h0303, 16'h0404, 16'h0505};
    {gbcd, gbin} = {dfcd_pkg::GAIN_DIRECT, dfcd_pkg::GAIN_DIRECT};
    coast = dfcd_pkg::COAST_DISABLE;
    ramp = 16'h07D0;
    rng = 32'h0000AE56;
    set_m(9999);
    {sel, last, fails, samples_checked, cycles} = {32'd1, 32'd0, 32'd0, 32'd0, 32'd0};
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    check(32'(inc), 1, "increment reset");
    check(32'(src), 32'(dfcd_pkg::DFCD_SRC_VOLT), "reset source");
    check(32'(ramp_o), 32'(ramp), "ramp reference");
    end_test("reset");
    set_m(10);
    for (int s = 0; s < 4; s++) begin
      wr_inc(s);
      check(32'(inc), s, "increment write");
      send(16'h0111);
      check(32'(freq), exp_f(), "bcd scaled");
      check(32'(direct), 1, "direct flag set");
    end
    set_m(11);
    for (int s = 3; s >= 0; s--) begin
      wr_inc(s);
      rng = xs(rng);
      send(rng[15:0]);
      check(32'(freq), exp_f(), "binary scaled");
    end
    end_test("increments");
    gbcd = 16'h1770;
    set_m(10);
    send(16'h0111);
    check(32'(direct), 0, "direct flag");
    check(32'(freq), exp_f(), "raw count");
    gbcd = dfcd_pkg::GAIN_DIRECT;
    run = 1'b1;
    wr_inc(2);
    check(32'(inc), 0, "running write");
    check(n, 1, "refused pulse");
    send(16'h0123);
    check(32'(rej), 0, "reject flag clear");
    send(16'h01A3);
    check(32'(rej), 1, "reject flag");
    check(32'(freq), exp_f(), "kept value");
    run = 1'b0;
    set_m(11);
    send(16'h00A5);
    set_m(10);
    last = 0;
    settle();
    check(32'(freq), exp_f(), "coding switch");
    end_test("refusals");
    wr_inc(1);
    for (int k = 0; k < 8; k++) begin
      set_m(k % 4 + (k / 4) * 10);
      rng = xs(rng);
      comp = {8'h00, rng[7:0]};
      send(16'h1234);
      check(32'(freq), exp_f(), "width and compensation");
    end
    comp = 16'h0000;
    timing = 4'h1;
    set_m(11);
    send(16'h0456);
    check(32'(freq), exp_f(), "strobe hold");
    timing = 4'h0;
    end_test("methods");
    set_m(9999);
    fv = {f_in, f_ms, f_pid, f_cur, f_v};
    for (int k = 0; k < 5; k++) begin
      {inch, ms, pid, cur} = {k > 3, 4'(k > 2), k > 1, k > 0};
      settle();
      check(32'(src), 32'({3'h6, 3'h2, 3'h3, 3'h1, 3'h0} >> 3 * k) & 7, "priority");
      check(32'(freq), 32'(fv[16 * k +: 16]), "priority value");
    end
    {inch, pid} = 2'b00;
    set_m(10);
    dfcd_ctrl_model_inst.manual_zero();
    send(16'h0042);
    check(32'(src), 32'(dfcd_pkg::DFCD_SRC_DIG), "masked sources");
    check(32'(freq), exp_f(), "digital value");
    rs_in = 1'b1;
    settle();
    check(32'(rsel), 0, "restart disabled");
    coast = 14'h0064;
    rng = xs(rng);
    ramp = rng[15:0];
    settle();
    check(32'(rsel), 1, "restart kept");
    check(32'(ramp_o), 32'(ramp), "ramp reference");
    end_test("sources");
    stop_test();
  end
endmodule : dfcd_tb_top
`default_nettype wire
